/* File: rhs_defs.svh */
`ifndef RHS_DEFS_SVH
`define RHS_DEFS_SVH

// clock and timing
`define RHS_CLK_NS     40
`define RHS_QTR_NS     2500
`define RHS_QTR_CYC    ((`RHS_QTR_NS + `RHS_CLK_NS - 1) / `RHS_CLK_NS)
`define RHS_PWR_MS     2000
`define RHS_PWR_CYC    (`RHS_PWR_MS * 1000000 / `RHS_CLK_NS)
`define RHS_TMO_MS     500
`define RHS_TMO_CYC    (`RHS_TMO_MS * 1000000 / `RHS_CLK_NS)

// software register offsets
`define RHS_A_CTRL     4'h0
`define RHS_A_STAT     4'h1
`define RHS_A_CFG      4'h2
`define RHS_A_TIME     4'h3
`define RHS_A_ALW      4'ha
`define RHS_A_ALD      4'hd

// control register bits
`define RHS_C_SETT     0
`define RHS_C_READT    1
`define RHS_C_APROG    2
`define RHS_C_ACANC    3
`define RHS_C_WCFG     4
`define RHS_C_AUTO     5
`define RHS_C_REDUCE   6

// status register bits
`define RHS_S_BUSY     0
`define RHS_S_READY    1
`define RHS_S_COLD     2
`define RHS_S_NACK     3
`define RHS_S_TMO      4
`define RHS_S_FULL     5

// clock chip map
`define RHS_DEV_ADDR   7'h32
`define RHS_R_SEC      8'h00
`define RHS_R_ALW      8'h08
`define RHS_R_ALD      8'h0b
`define RHS_R_CTL1     8'h0e
`define RHS_R_CTL2     8'h0f
`define RHS_B_COLD     4
`define RHS_B_PFLAG    2
`define RHS_B_WEEKLY_ALARM_ENABLE     7
`define RHS_B_DAILY_ALARM_ENABLE     6
`define RHS_B_LEVEL    2
`define RHS_CTL2_KEEP  8'hff
`define RHS_ALW_OFF    8'h55
`define RHS_ALD_OFF    8'h56
`define RHS_N_TIME     4'h7
`define RHS_N_SUB      4'h5

`endif

/* File: rhs_pkg.sv */
package rhs_pkg;

	typedef enum logic [1:0] {
		RHS_OP_START = 2'h0,
		RHS_OP_STOP  = 2'h1,
		RHS_OP_WR    = 2'h2,
		RHS_OP_RD    = 2'h3
	} rhs_op_e;

	typedef enum logic [1:0] {
		RHS_E_IDLE  = 2'h0,
		RHS_E_START = 2'h1,
		RHS_E_BIT   = 2'h3,
		RHS_E_STOP  = 2'h2
	} rhs_eng_e;

	typedef enum logic [3:0] {
		RHS_P_IDLE  = 4'h0,
		RHS_P_START = 4'h1,
		RHS_P_SADR  = 4'h3,
		RHS_P_REG   = 4'h2,
		RHS_P_DATA  = 4'h6,
		RHS_P_RST   = 4'h7,
		RHS_P_SADRR = 4'h5,
		RHS_P_RDAT  = 4'h4,
		RHS_P_STOP  = 4'hc
	} rhs_ph_e;

	typedef enum logic [3:0] {
		RHS_J_NONE  = 4'h0,
		RHS_J_COLD  = 4'h1,
		RHS_J_SETT  = 4'h3,
		RHS_J_READT = 4'h2,
		RHS_J_CLRF  = 4'h6,
		RHS_J_CFG   = 4'h7,
		RHS_J_ADIS  = 4'h5,
		RHS_J_AW    = 4'h4,
		RHS_J_AD    = 4'hc
	} rhs_job_e;

endpackage

/* File: rhs_eng_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface rhs_eng_if;
	import rhs_pkg::*;
	logic       req;
	rhs_op_e    op;
	logic [7:0] wbyte;
	logic       ack;
	logic       done;
	logic       nack;
	logic [7:0] rbyte;
	modport ctl (output req, op, wbyte, ack, input done, nack, rbyte);
	modport eng (input req, op, wbyte, ack, output done, nack, rbyte);
endinterface
`default_nettype wire

/* File: rhs_bit_engine.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rhs_defs.svh"
module rhs_bit_engine
	import rhs_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic rst,
	rhs_eng_if.eng    eif,
	input  wire logic scl_i,
	output logic      scl_oe_n,
	input  wire logic sda_i,
	output logic      sda_oe_n
);

	typedef struct packed {
		rhs_eng_e   st;
		logic [1:0] q;
		logic [6:0] tick;
		logic [3:0] bitn;
		logic [7:0] sh;
		logic       rd;
		logic       ack;
		logic       smp;
		logic       scl_low;
		logic       sda_low;
		logic       done;
		logic       nack;
	} rhs_eng_s;

	rhs_eng_s r;
	rhs_eng_s next_r;

	localparam logic [6:0] QTR = 7'(`RHS_QTR_CYC);

	// quarter-bit sequencer; a slave holding scl low stretches the high
	always_comb begin
		logic qend;
		qend = 1'b0;
		next_r = r;
		next_r.done = 1'b0;
		if (r.st == RHS_E_IDLE) begin
			if (eif.req) begin
				next_r.q = 2'h0;
				next_r.tick = 7'h00;
				next_r.bitn = 4'h0;
				next_r.sh = eif.wbyte;
				next_r.rd = (eif.op == RHS_OP_RD);
				next_r.ack = eif.ack;
				case (eif.op)
					RHS_OP_START: next_r.st = RHS_E_START;
					RHS_OP_STOP:  next_r.st = RHS_E_STOP;
					default:      next_r.st = RHS_E_BIT;
				endcase
			end
		end else if (r.q == 2'h1 && !scl_i) begin
			next_r.tick = r.tick;
		end else if (r.tick == QTR - 7'h01) begin
			next_r.tick = 7'h00;
			next_r.q = r.q + 2'h1;
			qend = 1'b1;
		end else begin
			next_r.tick = r.tick + 7'h01;
		end
		if (qend && r.q == 2'h1 && r.st == RHS_E_BIT) begin
			next_r.smp = sda_i;
		end
		if (qend && r.q == 2'h3) begin
			if (r.st == RHS_E_BIT) begin
				next_r.bitn = r.bitn + 4'h1;
				if (r.bitn == 4'h8) begin
					next_r.nack = r.smp;
					next_r.st = RHS_E_IDLE;
					next_r.done = 1'b1;
				end else begin
					next_r.sh = {r.sh[6:0], r.smp};
				end
			end else begin
				next_r.st = RHS_E_IDLE;
				next_r.done = 1'b1;
			end
		end
		// line levels for the quarter now starting
		case (next_r.st)
			RHS_E_START: begin
				next_r.scl_low = (next_r.q == 2'h3);
				next_r.sda_low = next_r.q[1];
			end
			RHS_E_STOP: begin
				next_r.scl_low = (next_r.q == 2'h0);
				next_r.sda_low = !next_r.q[1];
			end
			RHS_E_BIT: begin
				next_r.scl_low = (next_r.q == 2'h0 || next_r.q == 2'h3);
				if (next_r.bitn == 4'h8)
					next_r.sda_low = next_r.rd & next_r.ack;
				else
					next_r.sda_low = !next_r.rd & !next_r.sh[7];
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			r <= '{st: RHS_E_IDLE, default: '0};
		else
			r <= next_r;
	end

	assign eif.done  = r.done;
	assign eif.nack  = r.nack;
	assign eif.rbyte = r.sh;
	assign scl_oe_n  = !r.scl_low;
	assign sda_oe_n  = !r.sda_low;

endmodule
`default_nettype wire

/* File: rhs_host.sv */
// Overview of operation
// - wait the start-up time after power-up before any access to the clock
// - write seconds through year in one transaction, no stop between
// - read seconds through year in one transaction, no stop between
// - each transaction from start to stop lasts under half a second
// - paced reads use level-mode interrupt and finish within half a second
// - writing the periodic flag to zero releases the periodic interrupt
// - reduced scheme reads all counters once after setting, later a subset
// - clear the alarm enable bits before loading alarm settings
// - set the alarm enable bits only after all alarm settings are written
// - cancel alarms by writing the fixed cancel patterns to both groups
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "rhs_defs.svh"
module rhs_host
	import rhs_pkg::*;
#(
	parameter int unsigned PWR_CYC = `RHS_PWR_CYC,
	parameter int unsigned TMO_CYC = `RHS_TMO_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [3:0] bus_addr,
	input  wire logic [7:0] bus_wdata,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	output logic      [7:0] bus_rdata,
	input  wire logic       irq_out_a_n,
	input  wire logic       scl_i,
	output logic            scl_o,
	output logic            scl_oe_n,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_n
);

	typedef struct packed {
		rhs_job_e        job;
		rhs_ph_e         ph;
		logic            wait_eng;
		logic [3:0]      idx;
		logic [25:0]     pwr;
		logic [23:0]     tmo;
		logic [6:0][7:0] tbuf;
		logic [2:0][7:0] aw;
		logic [1:0][7:0] ad;
		logic [7:0]      cfg;
		logic [4:0]      pend;
		logic            auto_en;
		logic            reduce;
		logic            full_next;
		logic            cancel;
		logic            ready;
		logic            cold;
		logic            err_nack;
		logic            err_tmo;
		logic            req;
		rhs_op_e         op;
		logic [7:0]      wbyte;
		logic            ack;
		logic [7:0]      rdata;
	} rhs_host_s;

	rhs_host_s r;
	rhs_host_s next_r;
	rhs_eng_if eif ();

	// device register where each job begins
	function automatic logic [7:0] job_reg(input rhs_job_e j);
		case (j)
			RHS_J_COLD, RHS_J_CLRF: job_reg = `RHS_R_CTL2;
			RHS_J_CFG, RHS_J_ADIS:  job_reg = `RHS_R_CTL1;
			RHS_J_AW:               job_reg = `RHS_R_ALW;
			RHS_J_AD:               job_reg = `RHS_R_ALD;
			default:                job_reg = `RHS_R_SEC;
		endcase
	endfunction

	// bytes per job; reduced scheme trims paced reads to a subset
	function automatic logic [3:0] job_len(input rhs_host_s s);
		case (s.job)
			RHS_J_SETT:  job_len = `RHS_N_TIME;
			RHS_J_READT: job_len = (s.reduce && !s.full_next) ?
				`RHS_N_SUB : `RHS_N_TIME;
			RHS_J_AW:    job_len = 4'h3;
			RHS_J_AD:    job_len = 4'h2;
			default:     job_len = 4'h1;
		endcase
	endfunction

	// control value: level mode forced when reads are paced
	function automatic logic [7:0] ctl1_val(input rhs_host_s s,
			input logic alarms);
		logic [7:0] v;
		v = s.cfg;
		if (s.auto_en)
			v[`RHS_B_LEVEL] = 1'b1;
		if (!alarms) begin
			v[`RHS_B_WEEKLY_ALARM_ENABLE] = 1'b0;
			v[`RHS_B_DAILY_ALARM_ENABLE] = 1'b0;
		end
		return v;
	endfunction

	// data byte number i of a write job
	function automatic logic [7:0] wr_byte(input rhs_host_s s,
			input logic [3:0] i);
		case (s.job)
			RHS_J_SETT: wr_byte = s.tbuf[i[2:0]];
			RHS_J_CLRF: begin
				wr_byte = `RHS_CTL2_KEEP;
				wr_byte[`RHS_B_PFLAG] = 1'b0;
			end
			RHS_J_CFG:  wr_byte = ctl1_val(s, 1'b1);
			RHS_J_ADIS: wr_byte = ctl1_val(s, 1'b0);
			RHS_J_AW:   wr_byte = s.cancel ? `RHS_ALW_OFF :
				s.aw[i[1:0]];
			RHS_J_AD:   wr_byte = s.cancel ? `RHS_ALD_OFF :
				s.ad[i[0]];
			default:    wr_byte = 8'h00;
		endcase
	endfunction

	function automatic logic job_is_rd(input rhs_job_e j);
		return j == RHS_J_COLD || j == RHS_J_READT;
	endfunction

	// job that follows a finished one
	function automatic rhs_job_e job_after(input rhs_host_s s);
		case (s.job)
			RHS_J_READT: job_after = s.auto_en ? RHS_J_CLRF : RHS_J_NONE;
			RHS_J_ADIS:  job_after = RHS_J_AW;
			RHS_J_AW:    job_after = RHS_J_AD;
			RHS_J_AD:    job_after = s.cancel ? RHS_J_NONE : RHS_J_CFG;
			default:     job_after = RHS_J_NONE;
		endcase
	endfunction

	always_comb begin
		logic       last;
		logic [4:0] launch;
		logic [4:0] cmd;
		logic       end_job;
		logic [1:0] err_hit;
		err_hit = 2'h0;
		last = 1'b0;
		launch = 5'h00;
		cmd = 5'h00;
		end_job = 1'b0;
		next_r = r;
		next_r.req = 1'b0;
		next_r.rdata = 8'h00;
		last = (r.idx + 4'h1 == job_len(r));

		// software writes
		if (bus_wr) begin
			case (bus_addr)
				`RHS_A_CTRL: begin
					cmd = bus_wdata[4:0];
					next_r.auto_en = bus_wdata[`RHS_C_AUTO];
					next_r.reduce = bus_wdata[`RHS_C_REDUCE];
				end
				`RHS_A_CFG: next_r.cfg = bus_wdata;
				default: ;
			endcase
			if (bus_addr >= `RHS_A_TIME && bus_addr < `RHS_A_ALW)
				next_r.tbuf[3'(bus_addr - `RHS_A_TIME)] = bus_wdata;
			if (bus_addr >= `RHS_A_ALW && bus_addr < `RHS_A_ALD)
				next_r.aw[2'(bus_addr - `RHS_A_ALW)] = bus_wdata;
			if (bus_addr >= `RHS_A_ALD && bus_addr < 4'hf)
				next_r.ad[1'(bus_addr - `RHS_A_ALD)] = bus_wdata;
		end

		// software reads, answered next cycle
		if (bus_rd) begin
			case (bus_addr)
				`RHS_A_CTRL: next_r.rdata = {1'b0, r.reduce, r.auto_en,
					r.pend};
				`RHS_A_STAT: next_r.rdata = {2'h0, r.full_next, r.err_tmo,
					r.err_nack, r.cold, r.ready,
					r.job != RHS_J_NONE};
				`RHS_A_CFG: next_r.rdata = r.cfg;
				default: begin
					if (bus_addr >= `RHS_A_TIME && bus_addr < `RHS_A_ALW)
						next_r.rdata = r.tbuf[3'(bus_addr - `RHS_A_TIME)];
					else if (bus_addr >= `RHS_A_ALW &&
							bus_addr < `RHS_A_ALD)
						next_r.rdata = r.aw[2'(bus_addr - `RHS_A_ALW)];
					else if (bus_addr >= `RHS_A_ALD && bus_addr < 4'hf)
						next_r.rdata = r.ad[1'(bus_addr - `RHS_A_ALD)];
				end
			endcase
		end

		// start-up wait before the first access
		if (!r.ready) begin
			if (r.pwr == 26'(PWR_CYC - 1)) begin
				next_r.ready = 1'b1;
				next_r.job = RHS_J_COLD;
				next_r.ph = RHS_P_START;
			end else begin
				next_r.pwr = r.pwr + 26'h1;
			end
		end else if (r.job == RHS_J_NONE) begin
			// paced read wins; then fixed priority of commands
			if (r.auto_en && !irq_out_a_n) begin
				next_r.job = RHS_J_READT;
			end else if (r.pend[`RHS_C_SETT]) begin
				next_r.job = RHS_J_SETT;
				launch[`RHS_C_SETT] = 1'b1;
			end else if (r.pend[`RHS_C_READT]) begin
				next_r.job = RHS_J_READT;
				launch[`RHS_C_READT] = 1'b1;
			end else if (r.pend[`RHS_C_APROG]) begin
				next_r.job = RHS_J_ADIS;
				next_r.cancel = 1'b0;
				launch[`RHS_C_APROG] = 1'b1;
			end else if (r.pend[`RHS_C_ACANC]) begin
				next_r.job = RHS_J_ADIS;
				next_r.cancel = 1'b1;
				launch[`RHS_C_ACANC] = 1'b1;
			end else if (r.pend[`RHS_C_WCFG]) begin
				next_r.job = RHS_J_CFG;
				launch[`RHS_C_WCFG] = 1'b1;
			end
			if (next_r.job != RHS_J_NONE)
				next_r.ph = RHS_P_START;
		end

		// a new command is never lost to a launch in the same cycle
		next_r.pend = (r.pend & ~launch) | cmd;

		// transaction timer, aborts with a stop
		if (r.ph == RHS_P_IDLE || r.ph == RHS_P_STOP) begin
			next_r.tmo = 24'h0;
		end else if (r.tmo == 24'(TMO_CYC - 1)) begin
			next_r.err_tmo = 1'b1;
			err_hit[1] = 1'b1;
			next_r.ph = RHS_P_STOP;
			next_r.job = RHS_J_NONE;
			next_r.wait_eng = 1'b0;
		end else begin
			next_r.tmo = r.tmo + 24'h1;
		end

		// issue one engine op per phase, whole job in one transaction
		if (r.ph != RHS_P_IDLE && !r.wait_eng &&
				next_r.ph != RHS_P_STOP) begin
			next_r.req = 1'b1;
			next_r.wait_eng = 1'b1;
			next_r.ack = !last;
			case (r.ph)
				RHS_P_START, RHS_P_RST: next_r.op = RHS_OP_START;
				RHS_P_SADR: begin
					next_r.op = RHS_OP_WR;
					next_r.wbyte = {`RHS_DEV_ADDR, 1'b0};
				end
				RHS_P_SADRR: begin
					next_r.op = RHS_OP_WR;
					next_r.wbyte = {`RHS_DEV_ADDR, 1'b1};
				end
				RHS_P_REG: begin
					next_r.op = RHS_OP_WR;
					next_r.wbyte = job_reg(r.job);
				end
				RHS_P_DATA: begin
					next_r.op = RHS_OP_WR;
					next_r.wbyte = wr_byte(r, r.idx);
				end
				RHS_P_RDAT: next_r.op = RHS_OP_RD;
				default: next_r.op = RHS_OP_STOP;
			endcase
		end else if (r.ph == RHS_P_STOP && !r.wait_eng) begin
			next_r.req = 1'b1;
			next_r.wait_eng = 1'b1;
			next_r.op = RHS_OP_STOP;
		end

		// advance on completion
		if (r.wait_eng && eif.done) begin
			next_r.wait_eng = 1'b0;
			if (eif.nack && (r.ph == RHS_P_SADR || r.ph == RHS_P_REG ||
					r.ph == RHS_P_DATA || r.ph == RHS_P_SADRR)) begin
				next_r.err_nack = 1'b1;
				err_hit[0] = 1'b1;
				next_r.ph = RHS_P_STOP;
				next_r.job = RHS_J_NONE;
			end else begin
				case (r.ph)
					RHS_P_START: next_r.ph = RHS_P_SADR;
					RHS_P_SADR:  next_r.ph = RHS_P_REG;
					RHS_P_REG: begin
						next_r.idx = 4'h0;
						next_r.ph = job_is_rd(r.job) ? RHS_P_RST :
							RHS_P_DATA;
					end
					RHS_P_DATA: begin
						next_r.idx = r.idx + 4'h1;
						if (last)
							next_r.ph = RHS_P_STOP;
					end
					RHS_P_RST:   next_r.ph = RHS_P_SADRR;
					RHS_P_SADRR: next_r.ph = RHS_P_RDAT;
					RHS_P_RDAT: begin
						next_r.idx = r.idx + 4'h1;
						if (r.job == RHS_J_COLD)
							next_r.cold = eif.rbyte[`RHS_B_COLD];
						else
							next_r.tbuf[r.idx[2:0]] = eif.rbyte;
						if (last)
							next_r.ph = RHS_P_STOP;
					end
					RHS_P_STOP: begin
						next_r.ph = RHS_P_IDLE;
						end_job = 1'b1;
					end
					default: next_r.ph = RHS_P_IDLE;
				endcase
			end
		end

		// chain to the following job of the same sequence
		if (end_job && r.job != RHS_J_NONE) begin
			next_r.job = job_after(r);
			if (next_r.job != RHS_J_NONE)
				next_r.ph = RHS_P_START;
			if (r.job == RHS_J_SETT)
				next_r.full_next = 1'b1;
			else if (r.job == RHS_J_READT && job_len(r) == `RHS_N_TIME)
				next_r.full_next = 1'b0;
		end

		// error flags: write one to clear, a new error wins
		if (bus_wr && bus_addr == `RHS_A_STAT) begin
			if (bus_wdata[`RHS_S_NACK] && !err_hit[0])
				next_r.err_nack = 1'b0;
			if (bus_wdata[`RHS_S_TMO] && !err_hit[1])
				next_r.err_tmo = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst)
			r <= '{job: RHS_J_NONE, ph: RHS_P_IDLE, op: RHS_OP_START,
				default: '0};
		else
			r <= next_r;
	end

	assign eif.req   = r.req;
	assign eif.op    = r.op;
	assign eif.wbyte = r.wbyte;
	assign eif.ack   = r.ack;
	assign bus_rdata = r.rdata;
	assign scl_o     = 1'b0;
	assign sda_o     = 1'b0;

	// two-wire bit engine
	rhs_bit_engine u_eng (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.eif      (eif),
		.scl_i    (scl_i),
		.scl_oe_n (scl_oe_n),
		.sda_i    (sda_i),
		.sda_oe_n (sda_oe_n)
	);

endmodule
`default_nettype wire

/* File: rhs_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rhs_host_asserts #(
	parameter int unsigned PWR_CYC = 20,
	parameter int unsigned TMO_CYC = 30000
) (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic [3:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic       bus_wr,
	input wire logic       bus_rd,
	input wire logic [7:0] bus_rdata,
	input wire logic       irq_out_a_n,
	input wire logic       scl_i,
	input wire logic       scl_o,
	input wire logic       scl_oe_n,
	input wire logic       sda_i,
	input wire logic       sda_o,
	input wire logic       sda_oe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	int unsigned up_cnt;
	int unsigned txn_cnt;
	int unsigned irq_cnt;
	logic        auto_on;
	logic        in_txn;

	// start and stop are judged on the wire, so slave edges count too
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			up_cnt  <= 0;
			txn_cnt <= 0;
			irq_cnt <= 0;
			auto_on <= 1'b0;
			in_txn  <= 1'b0;
		end else begin
			if (up_cnt < PWR_CYC)
				up_cnt <= up_cnt + 1;
			if (bus_wr && bus_addr == 4'h0)
				auto_on <= bus_wdata[5];
			if (scl_i && $fell(sda_i))
				in_txn <= 1'b1;
			else if (scl_i && $rose(sda_i))
				in_txn <= 1'b0;
			txn_cnt <= in_txn ? txn_cnt + 1 : 0;
			irq_cnt <= (auto_on && !irq_out_a_n) ? irq_cnt + 1 : 0;
		end
	end

	sequence s_scl_up;
		$rose(scl_oe_n);
	endsequence
	sequence s_scl_down;
		$fell(scl_oe_n);
	endsequence

	a_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
		else $error("read data not zero outside the answer cycle");
	a_startup_quiet: assert property (up_cnt < PWR_CYC - 1 |-> scl_oe_n && sda_oe_n)
		else $error("bus touched during start-up wait");
	a_txn_bound: assert property (txn_cnt < TMO_CYC)
		else $error("transaction longer than the limit");
	a_irq_release: assert property (irq_cnt < 2 * TMO_CYC)
		else $error("paced interrupt not serviced in time");
	a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
		else $error("bus line driven high");
	a_scl_high_min: assert property (s_scl_up |-> scl_oe_n [*8])
		else $error("clock high phase too short");
	a_scl_low_min: assert property (s_scl_down |-> !scl_oe_n [*8])
		else $error("clock low phase too short");
	a_reset_release: assert property ($past(rst) |-> scl_oe_n && sda_oe_n && bus_rdata == 8'h00)
		else $error("outputs not idle after reset");
endmodule

bind rhs_host rhs_host_asserts #(
	.PWR_CYC(PWR_CYC),
	.TMO_CYC(TMO_CYC)
) i_chk (
	.clk_sys    (clk_sys),
	.rst        (rst),
	.bus_addr   (bus_addr),
	.bus_wdata  (bus_wdata),
	.bus_wr     (bus_wr),
	.bus_rd     (bus_rd),
	.bus_rdata  (bus_rdata),
	.irq_out_a_n(irq_out_a_n),
	.scl_i      (scl_i),
	.scl_o      (scl_o),
	.scl_oe_n   (scl_oe_n),
	.sda_i      (sda_i),
	.sda_o      (sda_o),
	.sda_oe_n   (sda_oe_n)
);
`default_nettype wire

/* File: rhs_rtc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rhs_rtc_model #(
	parameter logic [6:0] DEV = 7'h32
) (
	input  wire logic scl,
	input  wire logic sda,
	input  wire logic tick,
	output logic      sda_oe_n,
	output logic      irq_out_a_n
);
	logic [7:0] regs [16] = '{15: 8'h10, default: 8'h00};
	logic [7:0] sh;
	logic [7:0] tx;
	logic [3:0] ptr = 4'h0;
	logic       on = 1'b0;
	logic       rd = 1'b0;
	logic       ok = 1'b0;
	logic       mack = 1'b1;
	logic       al_hot = 1'b0;
	int         bitn = 0;
	int         byten = 0;
	int         wr_run = 0;
	int         last_run = 0;
	int         subsec = 0;

	initial sda_oe_n = 1'b1;

	// level mode: held low until the flag is written to zero
	assign irq_out_a_n = !(regs[15][2] && regs[14][2]);
	always @(posedge tick)
		regs[15][2] = 1'b1;

	// flag bits clear on zero, ignore ones
	task automatic put(input logic [3:0] a, input logic [7:0] d);
		if (a == 4'hf)
			regs[a] = regs[a] & d;
		else
			regs[a] = d;
		if (a == 4'h0)
			subsec = 0;
		if (a >= 4'h8 && a <= 4'hc && regs[14][7:6] != 2'b00)
			al_hot = 1'b1;
		wr_run++;
	endtask

	// start or repeated start restarts byte framing
	always @(negedge sda) begin
		if (scl) begin
			on = 1'b1;
			bitn = 0;
			byten = 0;
			rd = 1'b0;
			wr_run = 0;
		end
	end
	always @(posedge sda) begin
		if (scl && on) begin
			on = 1'b0;
			last_run = wr_run;
		end
	end

	always @(posedge scl) begin
		if (on) begin
			if (bitn < 8)
				sh = {sh[6:0], sda};
			else
				mack = sda;
			bitn++;
		end
	end

	// all drive changes happen while the clock line is low
	always @(negedge scl) begin
		if (on && bitn == 8) begin
			if (byten == 0) begin
				ok = (sh[7:1] == DEV);
				rd = sh[0];
			end else if (ok && !rd && byten == 1)
				ptr = sh[3:0];
			else if (ok && !rd) begin
				put(ptr, sh);
				ptr++;
			end
			sda_oe_n = !(ok && (byten == 0 || !rd));
			byten++;
		end else if (on && bitn == 9) begin
			bitn = 0;
			sda_oe_n = 1'b1;
			if (rd && ok && (byten == 1 || !mack)) begin
				tx = regs[ptr];
				ptr++;
				sda_oe_n = tx[7];
			end
		end else if (on && rd && ok && bitn > 0 && bitn < 8)
			sda_oe_n = tx[7 - bitn];
	end
endmodule
`default_nettype wire

/* File: rtc_host_access_sequencing_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rtc_host_access_sequencing_test;
	import rhs_pkg::*;
	localparam int unsigned PWR = 20;
	localparam int unsigned TMO = 30000;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic [3:0] bus_addr = 4'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic       bus_wr = 1'b0;
	logic       bus_rd = 1'b0;
	logic       tick = 1'b0;
	logic [7:0] bus_rdata;
	logic       irq_n;
	logic       scl_oe_n;
	logic       sda_oe_n;
	logic       m_sda_oe_n;
	wire        sda = sda_oe_n & m_sda_oe_n;
	int         n_mismatch = 0;
	int         n_checks = 0;
	logic [7:0] q;
	logic [7:0] tval [7] = '{8'h45, 8'h59, 8'h23, 8'h06, 8'h31, 8'h12, 8'h99};

	always #20 clk_sys = !clk_sys;

	// clock line has one driver only, so its level is the host enable
	rhs_host #(
		.PWR_CYC(PWR),
		.TMO_CYC(TMO)
	) i_dut (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.bus_addr   (bus_addr),
		.bus_wdata  (bus_wdata),
		.bus_wr     (bus_wr),
		.bus_rd     (bus_rd),
		.bus_rdata  (bus_rdata),
		.irq_out_a_n(irq_n),
		.scl_i      (scl_oe_n),
		.scl_o      (),
		.scl_oe_n   (scl_oe_n),
		.sda_i      (sda),
		.sda_o      (),
		.sda_oe_n   (sda_oe_n)
	);
	rhs_rtc_model i_rtc (
		.scl        (scl_oe_n),
		.sda        (sda),
		.tick       (tick),
		.sda_oe_n   (m_sda_oe_n),
		.irq_out_a_n(irq_n)
	);

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] exp,
			input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	// one strobe cycle; read data lands in q
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_addr <= a;
		bus_wdata <= d;
		bus_wr <= wr;
		bus_rd <= !wr;
		@(posedge clk_sys);
		bus_wr <= 1'b0;
		bus_rd <= 1'b0;
		#1 q = bus_rdata;
	endtask

	// bounded poll of the status register
	task automatic wait_stat(input logic [7:0] mask, input logic [7:0] val);
		for (int i = 0; i < 9000; i++) begin
			repeat (8) @(posedge clk_sys);
			bus(1'b0, 4'h1, 8'h00);
			if ((q & mask) === val)
				return;
		end
		check("status wait", val, q & mask);
		give_verdict();
	endtask

	task automatic t_startup();
		bus(1'b0, 4'h1, 8'h00);
		check("ready early", 8'h00, q & 8'h02);
		bus(1'b1, 4'hf, 8'hff);
		bus(1'b0, 4'hf, 8'h00);
		check("unmapped read", 8'h00, q);
		repeat (PWR + 4) @(posedge clk_sys);
		wait_stat(8'h03, 8'h02);
		check("ready and cold", 8'h06, q & 8'h06);
	endtask

	task automatic t_set_time();
		for (int i = 0; i < 7; i++)
			bus(1'b1, 4'(3 + i), tval[i]);
		bus(1'b1, 4'h0, 8'h01);
		wait_stat(8'h03, 8'h02);
		check("full read next", 8'h20, q & 8'h20);
		for (int i = 0; i < 7; i++)
			check("counter set", tval[i], i_rtc.regs[i]);
		check("bytes in one write", 8'h07, 8'(i_rtc.last_run));
	endtask

	// paced read: level mode, then read, then flag release
	task automatic t_auto_read();
		bus(1'b1, 4'h2, 8'h00);
		bus(1'b1, 4'h0, 8'h30);
		wait_stat(8'h03, 8'h02);
		check("level mode", 8'h04, i_rtc.regs[14] & 8'h04);
		bus(1'b0, 4'h0, 8'h00);
		check("ctrl readback", 8'h20, q);
		tick <= 1'b1;
		@(posedge clk_sys);
		tick <= 1'b0;
		wait_stat(8'h01, 8'h01);
		for (int i = 0; i < 40000 && irq_n !== 1'b1; i++)
			@(posedge clk_sys);
		check("irq released", 8'h01, {7'h00, irq_n});
		wait_stat(8'h03, 8'h02);
		check("flag cleared", 8'h10, i_rtc.regs[15]);
		check("full read done", 8'h00, q & 8'h20);
		for (int i = 0; i < 7; i++) begin
			bus(1'b0, 4'(3 + i), 8'h00);
			check("time read", tval[i], q);
		end
	endtask

	// enables are on beforehand, so a late disable would show
	task automatic t_cancel();
		bus(1'b1, 4'h2, 8'hc0);
		bus(1'b1, 4'h0, 8'h30);
		wait_stat(8'h03, 8'h02);
		bus(1'b1, 4'h0, 8'h28);
		wait_stat(8'h03, 8'h02);
		for (int i = 0; i < 3; i++)
			check("weekly cancel", 8'h55, i_rtc.regs[8 + i]);
		for (int i = 0; i < 2; i++)
			check("daily cancel", 8'h56, i_rtc.regs[11 + i]);
		check("disabled first", 8'h00, {7'h00, i_rtc.al_hot});
		check("enables off", 8'h00, i_rtc.regs[14] & 8'hc0);
	endtask

	initial begin
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		t_startup();
		t_set_time();
		t_auto_read();
		t_cancel();
		give_verdict();
	end
endmodule
`default_nettype wire
